// File: verilog/abcl_boost_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - Switch pulses keep 150 ns min on and off below 1818 kHz, 110 ns on and 40 ns off above 1818 kHz.
// - Sink voltages are sampled periodically and the target rises if any watched sink is low.
// - The target keeps falling until at least one watched sink touches the headroom threshold.
// - Only sinks enabled by the string count setting are watched.
// - Sinks flagged open or short are left out of the headroom check.
// - Before the sinks are active the target sits at 88 % from minimum to maximum.
// - Low overvoltage halts switching and sets its flag; switching resumes once it clears.
// - High overvoltage enters fault recovery and sets its flag.
// - Output undervolt starts a 110 ms timer.
// - Undervolt lasting the full timer enters recovery and sets the timeout flag.
// - A static high sync level enables spread spectrum, a low level disables it.
// - A clock on the sync input sets the switching timing.
// - On sync clock loss switching runs at the resistor rate, spread from the final level.
// - A sync clock of 100 to 2222 kHz selects external mode and disables spread.
// - The spread range code selects 3.3, 4.3, 5.3 or 7.2 % deviation.
// - The modulation rate code selects 200, 500, 800 or 1200 Hz.
module abcl_boost_ctrl #(
	parameter int UV_CYCLES      = abcl_pkg::UV_CYC,
	parameter int RECOVER_CYCLES = abcl_pkg::RECOVER_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        switch_clock_sync_input_i,
	input  wire logic        current_trip_i,
	input  wire logic        overvolt_low_level_i,
	input  wire logic        overvolt_high_level_i,
	input  wire logic        output_undervolt_level_i,
	input  wire logic        sinks_active_i,
	input  wire logic [3:0]  sink_below_i,
	input  wire logic [3:0]  sink_touch_i,
	input  wire logic [3:0]  sink_fault_i,
	output logic             gate_o,
	output logic [9:0]       boost_target_o,
	output logic             fault_recovery_o,
	output logic             overvolt_low_flag_o,
	output logic             overvolt_high_flag_o,
	output logic             undervolt_timeout_flag_o,
	output logic             irq_o
);
	localparam logic [11:0] LOSS   = 12'(abcl_pkg::LOSS_CYC);
	localparam logic [10:0] P_MAX  = 11'h7ff;
	localparam logic [3:0]  OFF_SAT = 4'hf;

	// Min times depend on the band of the period actually in use
	function automatic logic [3:0] min_on(input logic [10:0] per);
		min_on = (per <= 11'(abcl_pkg::HI_BAND_CYC)) ? 4'(abcl_pkg::HI_ON_CYC)
			: 4'(abcl_pkg::LO_ON_CYC);
	endfunction : min_on

	function automatic logic [3:0] min_off(input logic [10:0] per);
		min_off = (per <= 11'(abcl_pkg::HI_BAND_CYC)) ? 4'(abcl_pkg::HI_OFF_CYC)
			: 4'(abcl_pkg::LO_OFF_CYC);
	endfunction : min_off

	// Byte-lane merge for AXI writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				merge[i*8 +: 8] = d[i*8 +: 8];
	endfunction : merge

	abcl_pkg::abcl_ctrl_t ctrl_r, ctrl_nxt;
	abcl_pkg::abcl_evt_t  stat_r, stat_nxt, en_r, en_nxt, clr, evt;
	abcl_pkg::abcl_state_t st;

	// Sync detector state
	logic              sync_d_r;
	logic [11:0]       gap_r, gap_nxt;
	logic [1:0]        good_r, good_nxt;
	logic              ext_r, ext_nxt;
	logic [10:0]       ext_per_r, ext_per_nxt;
	logic              sy_rise, lost, spread_en;

	assign sy_rise   = switch_clock_sync_input_i & ~sync_d_r;
	assign spread_en = ~ext_r & sync_d_r;

	// Edge spacing check, lock and loss
	always_comb
	begin
		gap_nxt = sy_rise ? 12'h000 : ((gap_r == LOSS) ? gap_r : gap_r + 12'h001);
		good_nxt = good_r;
		ext_nxt = ext_r;
		ext_per_nxt = ext_per_r;
		lost = 1'b0;
		if (sy_rise)
		begin
			if (gap_r >= 12'(abcl_pkg::SYNC_SHORT_CYC - 1)
				&& gap_r <= 12'(abcl_pkg::SYNC_LONG_CYC - 1))
			begin
				ext_per_nxt = 11'(gap_r + 12'h001);
				good_nxt = (good_r == 2'(abcl_pkg::SYNC_LOCK)) ? good_r : good_r + 2'h1;
				if (good_r >= 2'(abcl_pkg::SYNC_LOCK - 1))
					ext_nxt = 1'b1;
			end
			else
			begin
				good_nxt = 2'h0;
				lost = ext_r;
				ext_nxt = 1'b0;
			end
		end
		else if (gap_r == LOSS - 12'h001)
		begin
			good_nxt = 2'h0;
			lost = ext_r;
			ext_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			sync_d_r <= 1'b0;
			gap_r <= LOSS;
			good_r <= 2'h0;
			ext_r <= 1'b0;
			ext_per_r <= 11'(abcl_pkg::SYNC_LONG_CYC);
		end
		else
		begin
			sync_d_r <= switch_clock_sync_input_i;
			gap_r <= gap_nxt;
			good_r <= good_nxt;
			ext_r <= ext_nxt;
			ext_per_r <= ext_per_nxt;
		end
	end

	// Triangle modulator for spread spectrum
	logic [9:0] mt_r, mt_nxt;
	logic [7:0] tri_r, tri_nxt;
	logic       dir_r, dir_nxt;

	always_comb
	begin
		mt_nxt = mt_r + 10'h001;
		tri_nxt = tri_r;
		dir_nxt = dir_r;
		if (mt_r >= 10'(abcl_pkg::MOD_TICK[ctrl_r.modulation_rate_select] - 1))
		begin
			mt_nxt = 10'h000;
			tri_nxt = dir_r ? tri_r + 8'h01 : tri_r - 8'h01;
			if (dir_r && tri_r == 8'hfe)
				dir_nxt = 1'b0;
			else if (!dir_r && tri_r == 8'h01)
				dir_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			mt_r <= 10'h000;
			tri_r <= 8'h80;
			dir_r <= 1'b1;
		end
		else
		begin
			mt_r <= mt_nxt;
			tri_r <= tri_nxt;
			dir_r <= dir_nxt;
		end
	end

	// Switching cycle and gate
	logic        rec_r, rec_nxt, halt, start;
	logic [10:0] cyc_r, cyc_nxt, per_r, per_nxt;
	logic [3:0]  offc_r, offc_nxt;
	logic        gate_r, gate_nxt;
	int          base, dev, per_i;

	assign halt = overvolt_low_level_i | rec_r;
	assign start = ext_r ? sy_rise : (cyc_r + 11'h001 >= per_r);

	always_comb
	begin
		base = abcl_pkg::FSET_PER[ctrl_r.frequency_set_resistor];
		dev = (base * abcl_pkg::SPR_K[ctrl_r.spread_range]) >>> abcl_pkg::SPR_SH;
		per_i = spread_en ? base + ((dev * int'(tri_r)) >>> abcl_pkg::TRI_SH) - dev : base;
		per_nxt = start ? (ext_r ? ext_per_r : 11'(per_i)) : per_r;
		cyc_nxt = start ? 11'h000 : ((cyc_r == P_MAX) ? cyc_r : cyc_r + 11'h001);
		offc_nxt = gate_r ? 4'h0 : ((offc_r == OFF_SAT) ? offc_r : offc_r + 4'h1);
		gate_nxt = gate_r;
		// An early sync edge would shorten off time, so a pulse is skipped instead
		// A saturated off counter means a long gap; its +1 would wrap to zero
		if (start)
			gate_nxt = !halt && (offc_r == OFF_SAT || offc_r + 4'h1 >= min_off(per_nxt));
		else if (gate_r && (cyc_r + 11'h001 >= min_on(per_r)) && (current_trip_i || halt))
			gate_nxt = 1'b0;
		else if (gate_r && cyc_r + 11'h001 + 11'(min_off(per_r)) >= per_r)
			gate_nxt = 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			cyc_r <= 11'h000;
			per_r <= 11'(abcl_pkg::FSET_PER[0]);
			offc_r <= OFF_SAT;
			gate_r <= 1'b0;
		end
		else
		begin
			cyc_r <= cyc_nxt;
			per_r <= per_nxt;
			offc_r <= offc_nxt;
			gate_r <= gate_nxt;
		end
	end

	// Adaptive target; the start value is also the post-recovery value
	logic [9:0]  smp_r, smp_nxt;
	logic [9:0]  tgt_r, tgt_nxt;
	logic [3:0]  watch;

	assign watch = 4'((5'h02 << ctrl_r.string_count_setting) - 5'h01) & ~sink_fault_i;

	always_comb
	begin
		smp_nxt = (smp_r >= 10'(abcl_pkg::SAMPLE_CYC - 1)) ? 10'h000 : smp_r + 10'h001;
		tgt_nxt = tgt_r;
		if (!sinks_active_i || rec_r)
			tgt_nxt = 10'(abcl_pkg::TGT_INIT);
		else if (smp_r == 10'h000)
		begin
			if (|(sink_below_i & watch))
			begin
				if (tgt_r != 10'(abcl_pkg::TGT_MAX))
					tgt_nxt = tgt_r + 10'h001;
			end
			else if (watch != 4'h0 && !(|(sink_touch_i & watch)))
			begin
				if (tgt_r != 10'(abcl_pkg::TGT_MIN))
					tgt_nxt = tgt_r - 10'h001;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			smp_r <= 10'h000;
			tgt_r <= 10'(abcl_pkg::TGT_INIT);
		end
		else
		begin
			smp_r <= smp_nxt;
			tgt_r <= tgt_nxt;
		end
	end

	// Undervolt timer and fault recovery
	logic [22:0] uv_r, uv_nxt;
	logic [22:0] rc_r, rc_nxt;
	logic        uv_exp;

	always_comb
	begin
		uv_nxt = 23'h000000;
		uv_exp = 1'b0;
		rc_nxt = 23'h000000;
		rec_nxt = rec_r;
		if (output_undervolt_level_i && !rec_r)
		begin
			uv_nxt = uv_r + 23'h000001;
			if (uv_r == 23'(UV_CYCLES - 1))
			begin
				uv_exp = 1'b1;
				uv_nxt = 23'h000000;
			end
		end
		if (rec_r)
		begin
			rc_nxt = rc_r + 23'h000001;
			if (rc_r == 23'(RECOVER_CYCLES - 1))
				rec_nxt = 1'b0;
		end
		if (overvolt_high_level_i || uv_exp)
		begin
			rec_nxt = 1'b1;
			rc_nxt = 23'h000000;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			uv_r <= 23'h000000;
			rc_r <= 23'h000000;
			rec_r <= 1'b0;
		end
		else
		begin
			uv_r <= uv_nxt;
			rc_r <= rc_nxt;
			rec_r <= rec_nxt;
		end
	end

	// Events and readback
	assign evt = '{sync_lost: lost, uv_timeout: uv_exp, over_hi: overvolt_high_level_i,
		over_lo: overvolt_low_level_i};
	assign st = '{target: tgt_r, rsv: 12'h000, halted: halt, recovery: rec_r,
		spread: spread_en, ext_sync: ext_r};

	// AXI4-Lite slave and register file
	logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [7:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
	logic [3:0]  w_strb_r, w_strb_nxt;
	logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
	logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, irq_r, irq_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0]  wa, ra;

	assign wa = {aw_addr_r[7:2], 2'b00};
	assign ra = {s_axi_araddr_i[7:2], 2'b00};

	always_comb
	begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r && !s_axi_bready_i;
		bresp_nxt = bresp_r;
		ctrl_nxt = ctrl_r;
		en_nxt = en_r;
		clr = '0;
		if (s_axi_awvalid_i && awready_r)
		begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_r)
		begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata_i;
			w_strb_nxt = s_axi_wstrb_i;
		end
		if (aw_have_r && w_have_r && !bvalid_r)
		begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = abcl_pkg::RESP_OKAY;
			unique case (wa)
				abcl_pkg::ADDR_CTRL:
					ctrl_nxt = abcl_pkg::abcl_ctrl_t'(merge(32'(ctrl_r), w_data_r, w_strb_r)
						[$bits(abcl_pkg::abcl_ctrl_t)-1:0]);
				abcl_pkg::ADDR_IRQ_EN:
					en_nxt = abcl_pkg::abcl_evt_t'(merge(32'(en_r), w_data_r, w_strb_r)
						[$bits(abcl_pkg::abcl_evt_t)-1:0]);
				abcl_pkg::ADDR_IRQ_CLR:
					if (w_strb_r[0])
						clr = abcl_pkg::abcl_evt_t'(w_data_r[$bits(abcl_pkg::abcl_evt_t)-1:0]);
				abcl_pkg::ADDR_STATUS, abcl_pkg::ADDR_STATE:
					bresp_nxt = abcl_pkg::RESP_OKAY; // Read-only, write ignored
				default:
					bresp_nxt = abcl_pkg::RESP_SLVERR;
			endcase
		end
		awready_nxt = !aw_have_nxt;
		wready_nxt = !w_have_nxt;
		// Set wins over a clear in the same cycle
		stat_nxt = (stat_r & ~clr) | evt;
		irq_nxt = |(stat_r & en_r);
		rvalid_nxt = rvalid_r && !s_axi_rready_i;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid_i && arready_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = abcl_pkg::RESP_OKAY;
			unique case (ra)
				abcl_pkg::ADDR_CTRL:    rdata_nxt = 32'(ctrl_r);
				abcl_pkg::ADDR_STATUS:  rdata_nxt = 32'(stat_r);
				abcl_pkg::ADDR_IRQ_EN:  rdata_nxt = 32'(en_r);
				abcl_pkg::ADDR_IRQ_CLR: rdata_nxt = 32'h00000000;
				abcl_pkg::ADDR_STATE:   rdata_nxt = 32'(st);
				default:
				begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = abcl_pkg::RESP_SLVERR;
				end
			endcase
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
			ctrl_r <= abcl_pkg::CTRL_RST;
			en_r <= '0;
			stat_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			ctrl_r <= ctrl_nxt;
			en_r <= en_nxt;
			stat_r <= stat_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready_o = awready_r;
	assign s_axi_wready_o = wready_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_arready_o = arready_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;
	assign gate_o = gate_r;
	assign boost_target_o = tgt_r;
	assign fault_recovery_o = rec_r;
	assign overvolt_low_flag_o = stat_r.over_lo;
	assign overvolt_high_flag_o = stat_r.over_hi;
	assign undervolt_timeout_flag_o = stat_r.uv_timeout;
	assign irq_o = irq_r;
endmodule : abcl_boost_ctrl

// File: pkg/abcl_pkg.sv
package abcl_pkg;
	// Core clock
	localparam int CLK_KHZ = 50000;
	localparam int CLK_NS  = 20;

	// Minimum switch times per frequency band, rounded up to whole cycles
	localparam int LO_MIN_ON_NS  = 150;
	localparam int LO_MIN_OFF_NS = 150;
	localparam int HI_MIN_ON_NS  = 110;
	localparam int HI_MIN_OFF_NS = 40;
	localparam int HI_BAND_KHZ   = 1818;
	localparam int LO_ON_CYC     = (LO_MIN_ON_NS + CLK_NS - 1) / CLK_NS;
	localparam int LO_OFF_CYC    = (LO_MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int HI_ON_CYC     = (HI_MIN_ON_NS + CLK_NS - 1) / CLK_NS;
	localparam int HI_OFF_CYC    = (HI_MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int HI_BAND_CYC   = CLK_KHZ / HI_BAND_KHZ;

	// Internal switching frequency per resistor code
	localparam int FSET_KHZ [8] = '{400, 200, 303, 100, 500, 1818, 2000, 2222};
	localparam int FSET_PER [8] = '{CLK_KHZ / FSET_KHZ[0], CLK_KHZ / FSET_KHZ[1],
		CLK_KHZ / FSET_KHZ[2], CLK_KHZ / FSET_KHZ[3], CLK_KHZ / FSET_KHZ[4],
		CLK_KHZ / FSET_KHZ[5], CLK_KHZ / FSET_KHZ[6], CLK_KHZ / FSET_KHZ[7]};

	// Sync acceptance band and loss timeout
	localparam int SYNC_MIN_KHZ   = 100;
	localparam int SYNC_MAX_KHZ   = 2222;
	localparam int SYNC_LONG_CYC  = CLK_KHZ / SYNC_MIN_KHZ;
	localparam int SYNC_SHORT_CYC = CLK_KHZ / SYNC_MAX_KHZ;
	localparam int SYNC_LOCK      = 2;
	localparam int LOSS_PERIODS   = 4;
	localparam int LOSS_CYC       = SYNC_LONG_CYC * LOSS_PERIODS;

	// Spread deviation in 1/1024 of the period: 3.3, 4.3, 5.3, 7.2 %
	localparam int SPR_SH     = 10;
	localparam int SPR_K [4]  = '{34, 44, 54, 74};
	localparam int MOD_HZ [4] = '{200, 500, 800, 1200};
	localparam int MOD_STEPS  = 512;
	localparam int TRI_SH     = 7;
	localparam int MOD_TICK [4] = '{CLK_KHZ * 1000 / (MOD_HZ[0] * MOD_STEPS),
		CLK_KHZ * 1000 / (MOD_HZ[1] * MOD_STEPS), CLK_KHZ * 1000 / (MOD_HZ[2] * MOD_STEPS),
		CLK_KHZ * 1000 / (MOD_HZ[3] * MOD_STEPS)};

	// Adaptive target
	localparam int TGT_W      = 10;
	localparam int TGT_MIN    = 0;
	localparam int TGT_MAX    = 1023;
	localparam int INIT_PCT   = 88;
	localparam int TGT_INIT   = TGT_MIN + (TGT_MAX - TGT_MIN) * INIT_PCT / 100;
	localparam int SAMPLE_US  = 10;
	localparam int SAMPLE_CYC = SAMPLE_US * CLK_KHZ / 1000;

	// Fault timers
	localparam int UV_MS       = 110;
	localparam int UV_CYC      = UV_MS * CLK_KHZ;
	localparam int RECOVER_MS  = 10;
	localparam int RECOVER_CYC = RECOVER_MS * CLK_KHZ;

	// Register map
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
	localparam logic [7:0] ADDR_STATE   = 8'h10;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic [1:0] string_count_setting;
		logic [2:0] frequency_set_resistor;
		logic [1:0] modulation_rate_select;
		logic [1:0] spread_range;
	} abcl_ctrl_t;

	typedef struct packed {
		logic sync_lost;
		logic uv_timeout;
		logic over_hi;
		logic over_lo;
	} abcl_evt_t;

	typedef struct packed {
		logic [TGT_W-1:0] target;
		logic [11:0]      rsv;
		logic             halted;
		logic             recovery;
		logic             spread;
		logic             ext_sync;
	} abcl_state_t;

	localparam abcl_ctrl_t CTRL_RST = '{string_count_setting: 2'h3,
		frequency_set_resistor: 3'h0, modulation_rate_select: 2'h0, spread_range: 2'h2};
endpackage : abcl_pkg

// File: verif/abcl_fet_model.sv
`timescale 1ns/100ps
// Switch FET and inductor: current ramps while the gate is on
module abcl_fet_model #(
	parameter int RAMP_CYC = 2
) (
	input  wire logic core_clk_i,
	input  wire logic gate_i,
	output logic      current_trip_o
);
	int on_cnt = 0;
	initial current_trip_o = 1'b0;
	// Peak current reached early, so the minimum on time is what ends the pulse
	always @(posedge core_clk_i)
	begin
		on_cnt <= gate_i ? on_cnt + 1 : 0;
		current_trip_o <= gate_i && (on_cnt + 1 >= RAMP_CYC);
	end
endmodule : abcl_fet_model

// File: verif/abcl_boost_ctrl_checker.sv
`timescale 1ns/100ps
module abcl_boost_ctrl_checker #(
	parameter int UV_CYCLES = 50
) (
	input wire logic       core_clk_i,
	input wire logic       resetn_i,
	input wire logic       overvolt_low_level_i,
	input wire logic       overvolt_high_level_i,
	input wire logic       output_undervolt_level_i,
	input wire logic       sinks_active_i,
	input wire logic [3:0] sink_below_i,
	input wire logic [3:0] sink_fault_i,
	input wire logic       gate_o,
	input wire logic [9:0] boost_target_o,
	input wire logic       fault_recovery_o,
	input wire logic       overvolt_low_flag_o,
	input wire logic       overvolt_high_flag_o,
	input wire logic       undervolt_timeout_flag_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [31:0] uv_run_r;
	logic [31:0] uv_run_nxt;
	// Length of the current undervolt stretch
	always_comb uv_run_nxt = output_undervolt_level_i ? uv_run_r + 32'h1 : 32'h0;
	always_ff @(posedge core_clk_i) uv_run_r <= resetn_i ? uv_run_nxt : 32'h0;

	a_gate_min_on: assert property ($rose(gate_o) |-> (gate_o || fault_recovery_o)[*6])
		else $error("gate pulse shorter than minimum on time");
	a_gate_min_off: assert property ($fell(gate_o) |-> (!gate_o)[*2])
		else $error("gate gap shorter than minimum off time");
	a_ovlo_halt: assert property (overvolt_low_level_i[*3] |-> !$rose(gate_o))
		else $error("gate switched during low overvoltage");
	a_ovlo_flag: assert property (overvolt_low_level_i |=> overvolt_low_flag_o)
		else $error("low overvoltage flag not set");
	a_ovhi_recov: assert property ($rose(overvolt_high_level_i) |=> fault_recovery_o
		&& overvolt_high_flag_o)
		else $error("high overvoltage without recovery and flag");
	a_uv_expiry: assert property (uv_run_r == UV_CYCLES |-> ##[0:2]
		(undervolt_timeout_flag_o && fault_recovery_o))
		else $error("undervolt timer expiry missed");
	a_uv_early: assert property ($rose(undervolt_timeout_flag_o) |-> uv_run_r + 2 >= UV_CYCLES)
		else $error("undervolt flag before timer expiry");
	a_target_init: assert property (!sinks_active_i |=> boost_target_o == 10'(abcl_pkg::TGT_INIT))
		else $error("target not at initial level");
	a_target_raise: assert property (sinks_active_i && !fault_recovery_o
		&& boost_target_o == $past(boost_target_o) + 10'h1
		|-> $past(|(sink_below_i & ~sink_fault_i)))
		else $error("target raised without a low sink");
	// Sink 0 is watched at every string count; the others may be unused
	a_target_lower: assert property (sinks_active_i && !fault_recovery_o
		&& boost_target_o + 10'h1 == $past(boost_target_o)
		|-> !$past(sink_below_i[0] && !sink_fault_i[0]))
		else $error("target lowered while a sink is low");

	// Main scenarios reached
	c_recovery: cover property ($rose(fault_recovery_o));
	c_uv_flag: cover property ($rose(undervolt_timeout_flag_o));
	c_raise: cover property (sinks_active_i && boost_target_o == $past(boost_target_o) + 10'h1);
endmodule : abcl_boost_ctrl_checker

bind abcl_boost_ctrl abcl_boost_ctrl_checker #(.UV_CYCLES(UV_CYCLES)) i_abcl_boost_ctrl_checker (
	.core_clk_i(core_clk_i),
	.resetn_i(resetn_i),
	.overvolt_low_level_i(overvolt_low_level_i),
	.overvolt_high_level_i(overvolt_high_level_i),
	.output_undervolt_level_i(output_undervolt_level_i),
	.sinks_active_i(sinks_active_i),
	.sink_below_i(sink_below_i),
	.sink_fault_i(sink_fault_i),
	.gate_o(gate_o),
	.boost_target_o(boost_target_o),
	.fault_recovery_o(fault_recovery_o),
	.overvolt_low_flag_o(overvolt_low_flag_o),
	.overvolt_high_flag_o(overvolt_high_flag_o),
	.undervolt_timeout_flag_o(undervolt_timeout_flag_o)
);

// File: verif/abcl_boost_ctrl_test.sv
`timescale 1ns/100ps
module abcl_boost_ctrl_test;
	localparam int UVC = 50;
	localparam int RCC = 40;
	logic        core_clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        sync_pin = 1'b0, sync_run = 1'b0, active = 1'b0;
	logic        ov_lo = 1'b0, ov_hi = 1'b0, uv = 1'b0;
	logic [3:0]  below = 4'h0, touch = 4'h0, fault = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, trip, gate, recov;
	logic        f_lo, f_hi, f_uv, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [9:0]  target;
	int          err_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          t0;

	abcl_boost_ctrl #(.UV_CYCLES(UVC), .RECOVER_CYCLES(RCC)) i_abcl_boost_ctrl (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.switch_clock_sync_input_i(sync_pin), .current_trip_i(trip),
		.overvolt_low_level_i(ov_lo), .overvolt_high_level_i(ov_hi),
		.output_undervolt_level_i(uv), .sinks_active_i(active), .sink_below_i(below),
		.sink_touch_i(touch), .sink_fault_i(fault), .gate_o(gate), .boost_target_o(target),
		.fault_recovery_o(recov), .overvolt_low_flag_o(f_lo), .overvolt_high_flag_o(f_hi),
		.undervolt_timeout_flag_o(f_uv), .irq_o(irq));

	abcl_fet_model #(.RAMP_CYC(2)) i_abcl_fet_model (
		.core_clk_i(core_clk_i), .gate_i(gate), .current_trip_o(trip));

	// 50 MHz core clock
	always #10 core_clk_i = ~core_clk_i;

	// External sync clock of 500 kHz while enabled
	always @(posedge core_clk_i)
		if (sync_run && (cyc % 50 == 0))
			sync_pin <= ~sync_pin;

	// Cycle count; a hung wait ends the run here
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : tick

	// Address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge core_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge core_clk_i);
			if (awvalid && awready)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do
			@(posedge core_clk_i);
		while (!bvalid);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge core_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge core_clk_i);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge core_clk_i);
		while (!rvalid);
		rready <= 1'b0;
		check(rdata & m, e);
		check({30'h0, rresp}, {30'h0, er});
	endtask : axi_read

	// Returns after the next gate rise, at a settled point
	task automatic wait_rise();
		@(posedge gate);
		@(negedge core_clk_i);
	endtask : wait_rise

	// Waits for the next target step and compares it
	task automatic step_to(input int exp);
		logic [9:0] old;
		old = target;
		do
			@(posedge core_clk_i);
		while (target === old);
		check({22'h0, target}, exp);
	endtask : step_to

	task automatic end_of_test();
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Main sequence
	initial
	begin
		tick(2);
		resetn_i <= 1'b1;
		tick(1);
		check({22'h0, target}, abcl_pkg::TGT_INIT);
		axi_read(8'h00, 32'h1ff, 32'h182, 2'h0);
		for (int i = 0; i < 4; i++)
		begin
			axi_write(8'h00, 32'h180 | (i << 2) | i, 2'h0);
			axi_read(8'h00, 32'h1ff, 32'h180 | (i << 2) | i, 2'h0);
		end
		axi_write(8'h14, 32'h1, 2'h2);
		axi_read(8'h14, 32'hffffffff, 32'h0, 2'h2);
		axi_write(8'h04, 32'hf, 2'h0);
		axi_read(8'h04, 32'hf, 32'h0, 2'h0);
		// Static sync levels pick spread on or off
		sync_pin <= 1'b1;
		tick(10);
		axi_read(8'h10, 32'h3, 32'h2, 2'h0);
		sync_pin <= 1'b0;
		tick(10);
		axi_read(8'h10, 32'h3, 32'h0, 2'h0);
		// External clock takes over the switching period
		sync_run <= 1'b1;
		tick(400);
		axi_read(8'h10, 32'h3, 32'h1, 2'h0);
		wait_rise();
		t0 = cyc;
		wait_rise();
		check(cyc - t0, 100);
		sync_run <= 1'b0;
		tick(1);
		sync_pin <= 1'b1;
		tick(2200);
		axi_read(8'h10, 32'h3, 32'h2, 2'h0);
		axi_read(8'h04, 32'h8, 32'h8, 2'h0);
		wait_rise();
		axi_write(8'h0c, 32'hf, 2'h0);
		// Low overvoltage halts switching and raises an enabled interrupt
		axi_write(8'h08, 32'h1, 2'h0);
		ov_lo <= 1'b1;
		tick(20);
		check(gate, 1'b0);
		check({f_lo, irq}, 2'h3);
		ov_lo <= 1'b0;
		wait_rise();
		axi_write(8'h0c, 32'h1, 2'h0);
		tick(3);
		check(irq, 1'b0);
		axi_read(8'h04, 32'h1, 32'h0, 2'h0);
		axi_write(8'h08, 32'h0, 2'h0);
		ov_lo <= 1'b1;
		tick(3);
		ov_lo <= 1'b0;
		tick(3);
		check({f_lo, irq}, 2'h2);
		// High overvoltage enters recovery at once
		ov_hi <= 1'b1;
		tick(1);
		ov_hi <= 1'b0;
		tick(2);
		check({recov, f_hi}, 2'h3);
		axi_read(8'h10, 32'h4, 32'h4, 2'h0);
		tick(RCC + 5);
		check(recov, 1'b0);
		// Undervolt shorter than the timer is forgiven, a full one is not
		uv <= 1'b1;
		tick(UVC - 10);
		uv <= 1'b0;
		tick(5);
		check({f_uv, recov}, 2'h0);
		uv <= 1'b1;
		tick(UVC + 5);
		uv <= 1'b0;
		check({f_uv, recov}, 2'h3);
		tick(RCC + 5);
		axi_write(8'h0c, 32'hf, 2'h0);
		// Adaptive target with the sinks running
		active <= 1'b1;
		below <= 4'h8;
		step_to(abcl_pkg::TGT_INIT + 1);
		fault <= 4'h8;
		step_to(abcl_pkg::TGT_INIT);
		fault <= 4'h0;
		below <= 4'h0;
		touch <= 4'h1;
		tick(600);
		check({22'h0, target}, abcl_pkg::TGT_INIT);
		axi_write(8'h00, 32'h2, 2'h0);
		below <= 4'h2;
		touch <= 4'h0;
		step_to(abcl_pkg::TGT_INIT - 1);
		end_of_test();
	end
endmodule : abcl_boost_ctrl_test
